// ---- design/lpt_pkg.sv ----
package lpt_pkg;

  // register byte offsets
  localparam logic [3:0] LPT_OFF_COUNT   = 4'h0;
  localparam logic [3:0] LPT_OFF_RELOAD  = 4'h4;
  localparam logic [3:0] LPT_OFF_CONTROL = 4'h8;
  localparam logic [3:0] LPT_OFF_STATUS  = 4'hc;
  localparam logic [3:0] LPT_OFF_MASK    = 4'h0;
  localparam int         LPT_ADDR_W      = 5;

  // control field positions
  localparam int LPT_CTL_ENABLE    = 0;
  localparam int LPT_CTL_PERIODIC  = 1;
  localparam int LPT_CTL_RUN       = 2;
  localparam int LPT_CTL_DBG_EN    = 3;
  localparam int LPT_CTL_FW_PAUSE  = 4;
  localparam int LPT_CTL_W         = 5;

  // status / mask field position
  localparam int LPT_ST_EXPIRY = 0;

  // reset values
  localparam logic [31:0]        LPT_COUNT_RST  = 32'h0000_0000;
  localparam logic [31:0]        LPT_RELOAD_RST = 32'h0000_0000;
  localparam logic [LPT_CTL_W-1:0] LPT_CTL_RST  = 5'h00;

  // ahb-lite encodings
  localparam logic [1:0] LPT_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LPT_HTRANS_SEQ    = 2'h3;
  localparam logic       LPT_HRESP_OKAY    = 1'b0;

  // ahb-lite request carrier
  typedef struct packed {
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic                  hready;
  } lpt_ahb_req_t;

endpackage

// ---- design/lpt_timer.sv ----
`timescale 1ns/1ns
// Summary of operation
// - live count readable/writable at 0x0, resets zero
// - run request loads reload, starts counting
// - reload change used only at start or periodic expiry
// - periodic mode reloads and continues at expiry
// - one-shot mode stops after expiry, no restart
// - one-shot expiry clears run request bit
// - run request with zero reload is refused
// - run request cleared stops, zeroes, no interrupt
// - firmware pause holds count, resume continues
// - debug pause enable lets halt input hold
// - enable low returns count, reload and control to default
// - expiry interrupt on 1-to-0 while counting
// - all counting logic on the slow clock
// - debug halt input shares processor halt signal
module lpt_timer
  import lpt_pkg::*;
(
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  // ahb-lite slave
  input  wire lpt_pkg::lpt_ahb_req_t ahb_req_i,
  input  wire logic [31:0]         hwdata_i,
  output logic [31:0]              hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  // debug halt, asynchronous to mclk
  input  wire logic                debug_halt_i,
  // interrupt
  output logic                     expiry_irq_o
);
  import lpt_pkg::*;

  // clocking: everything here runs on the one slow timer clock, so the
  // register bus and the counter share a domain and need no crossing.
  // the price is that bus accesses crawl at timer speed; a fast host
  // bridge in front of this block is expected to absorb that.
  // only the debug halt pin comes from elsewhere and is synchronised.

  // bus access state
  typedef enum {LPT_IDLE, LPT_WDATA} lpt_bus_st_t;

  lpt_bus_st_t                 bus_st;
  logic [LPT_ADDR_W-1:0]       wr_addr;
  logic [31:0]                 live_count;
  logic [31:0]                 reload_value;
  logic [LPT_CTL_W-1:0]        timer_control;
  logic                        irq_status;
  logic                        irq_mask;
  logic                        halt_meta;
  logic                        halt_sync;
  logic                        addr_ph;
  logic                        wr_en;
  logic                        wr_count;
  logic                        wr_reload;
  logic                        wr_ctl;
  logic                        wr_status;
  logic                        wr_mask;
  logic                        run_set;
  logic                        run_clr;
  logic                        counting;
  logic                        paused;
  logic                        expire;
  logic                        ctl_off;
  logic [31:0]                 next_rdata;

  // word index decode shared by read and write paths
  function automatic logic is_reg(input logic [LPT_ADDR_W-1:0] a,
                                  input logic [3:0] off,
                                  input logic hi);
    is_reg = (a[4] == hi) && (a[3:0] == off);
  endfunction

  // halt comes from the debug domain; two flops before use
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end
    else
    begin
      halt_meta <= debug_halt_i;
      halt_sync <= halt_meta;
    end
  end

  // accepted address phase; only whole-word transfers are expected
  assign addr_ph = ahb_req_i.hsel && ahb_req_i.hready &&
                   (ahb_req_i.htrans == LPT_HTRANS_NONSEQ ||
                    ahb_req_i.htrans == LPT_HTRANS_SEQ);

  // write data phase follows a write address phase by one cycle.
  // the address is captured at the address-phase edge and the data
  // word is applied one edge later, when hwdata stands on the bus.
  // back-to-back writes keep the machine in the data state so that
  // no write slot is lost between two consecutive transfers.
  // reads need no state: their data are registered in address phase.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      bus_st  <= LPT_IDLE;
      wr_addr <= '0;
    end
    else
    begin
      case (bus_st)
        LPT_IDLE:
        begin
          if (addr_ph && ahb_req_i.hwrite)
          begin
            bus_st  <= LPT_WDATA;
            wr_addr <= ahb_req_i.haddr[LPT_ADDR_W-1:0];
          end
        end
        LPT_WDATA:
        begin
          if (addr_ph && ahb_req_i.hwrite)
            wr_addr <= ahb_req_i.haddr[LPT_ADDR_W-1:0];
          else
            bus_st <= LPT_IDLE;
        end
        default: bus_st <= LPT_IDLE;
      endcase
    end
  end

  assign wr_en     = (bus_st == LPT_WDATA);
  assign wr_count  = wr_en && is_reg(wr_addr, LPT_OFF_COUNT, 1'b0);
  assign wr_reload = wr_en && is_reg(wr_addr, LPT_OFF_RELOAD, 1'b0);
  assign wr_ctl    = wr_en && is_reg(wr_addr, LPT_OFF_CONTROL, 1'b0);
  assign wr_status = wr_en && is_reg(wr_addr, LPT_OFF_STATUS, 1'b0);
  assign wr_mask   = wr_en && is_reg(wr_addr, LPT_OFF_MASK, 1'b1);

  // run request edge: a one written over a zero starts a load
  assign run_set = wr_ctl && hwdata_i[LPT_CTL_RUN] &&
                   !timer_control[LPT_CTL_RUN];
  assign run_clr = wr_ctl && !hwdata_i[LPT_CTL_RUN];

  // hold conditions: firmware pause, or halt when allowed
  assign paused = timer_control[LPT_CTL_FW_PAUSE] ||
                  (timer_control[LPT_CTL_DBG_EN] && halt_sync);
  assign counting = timer_control[LPT_CTL_ENABLE] &&
                    timer_control[LPT_CTL_RUN] && !paused;
  // a count that was written to zero never expires; only 1-to-0 does
  assign expire = counting && (live_count == 32'h0000_0001);

  // disable, by a write of enable low or by enable already low; the
  // write case clears at the data-phase edge, so only a read pipelined into
  // the disabling write's data phase still sees a stale count or reload word
  assign ctl_off = !timer_control[LPT_CTL_ENABLE] ||
                   (wr_ctl && !hwdata_i[LPT_CTL_ENABLE]);

  // control register; hardware clears of run win over no-op writes.
  // priority: reset and disable first, then a software write with its
  // refusal and same-cycle expiry cases, then the hardware run clear.
  // a write that lands in the expiry cycle of a one-shot run leaves run set
  // only if it writes run and periodic high; the timer then sits stopped at zero.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || (wr_ctl && !hwdata_i[LPT_CTL_ENABLE]))
      timer_control <= LPT_CTL_RST;
    else if (!timer_control[LPT_CTL_ENABLE] && !wr_ctl)
      timer_control <= LPT_CTL_RST;
    else if (wr_ctl)
    begin
      timer_control <= hwdata_i[LPT_CTL_W-1:0];
      if (run_set && reload_value == 32'h0000_0000)
        timer_control[LPT_CTL_RUN] <= 1'b0;
      else if (!run_set && hwdata_i[LPT_CTL_RUN] && expire &&
               !hwdata_i[LPT_CTL_PERIODIC])
        timer_control[LPT_CTL_RUN] <= 1'b0;
    end
    else if (expire && !timer_control[LPT_CTL_PERIODIC])
      timer_control[LPT_CTL_RUN] <= 1'b0;
  end

  // reload register; read only at start or periodic expiry.
  // a new value written while running waits in this register and is
  // only picked up by the counter at the next start or periodic reload.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || ctl_off)
      reload_value <= LPT_RELOAD_RST;
    else if (wr_reload)
      reload_value <= hwdata_i;
  end

  // live counter, all on the one slow timer clock
  // priority: disable, start, stop, software write, periodic reload,
  // then the plain decrement. a refused start (zero reload) leaves the
  // count untouched, since the timer never begins in that case.
  // the count stops at zero by itself so a one-shot run cannot wrap.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || ctl_off)
      live_count <= LPT_COUNT_RST;
    else if (run_set && reload_value != 32'h0000_0000)
      live_count <= reload_value;
    else if (run_clr)
      live_count <= LPT_COUNT_RST;
    else if (wr_count)
      live_count <= hwdata_i;
    else if (expire && timer_control[LPT_CTL_PERIODIC])
      live_count <= reload_value;
    else if (counting && live_count != 32'h0000_0000)
      live_count <= live_count - 32'h0000_0001;
  end

  // sticky expiry status, write one to clear; a new event wins.
  // an expiry that coincides with a stop or a count write is dropped:
  // software has just overridden the count, so the tick is not real.
  // status lives outside the timer registers and survives a disable,
  // so a pending tick is not lost when firmware shuts the timer down.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      irq_status <= 1'b0;
    else if (expire && !(run_set || run_clr || wr_count))
      irq_status <= 1'b1;
    else if (wr_status && hwdata_i[LPT_ST_EXPIRY])
      irq_status <= 1'b0;
  end

  // interrupt mask, one means pass
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      irq_mask <= 1'b0;
    else if (wr_mask)
      irq_mask <= hwdata_i[LPT_ST_EXPIRY];
  end

  // level interrupt from a flop; a stop never raises it
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      expiry_irq_o <= 1'b0;
    else
      expiry_irq_o <= irq_status && irq_mask;
  end

  // read mux; count is a plain word, no byte latching
  // the decode uses the address phase directly; unmapped words read 0.
  // control bits above the implemented field read back as zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (is_reg(ahb_req_i.haddr[LPT_ADDR_W-1:0], LPT_OFF_COUNT, 1'b0))
      next_rdata = live_count;
    else if (is_reg(ahb_req_i.haddr[LPT_ADDR_W-1:0], LPT_OFF_RELOAD, 1'b0))
      next_rdata = reload_value;
    else if (is_reg(ahb_req_i.haddr[LPT_ADDR_W-1:0], LPT_OFF_CONTROL, 1'b0))
      next_rdata[LPT_CTL_W-1:0] = timer_control;
    else if (is_reg(ahb_req_i.haddr[LPT_ADDR_W-1:0], LPT_OFF_STATUS, 1'b0))
      next_rdata[LPT_ST_EXPIRY] = irq_status;
    else if (is_reg(ahb_req_i.haddr[LPT_ADDR_W-1:0], LPT_OFF_MASK, 1'b1))
      next_rdata[LPT_ST_EXPIRY] = irq_mask;
  end

  // read data registered in the address phase; zero wait states
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      hrdata_o <= 32'h0000_0000;
    else if (addr_ph && !ahb_req_i.hwrite)
      hrdata_o <= next_rdata;
  end

  // always ready, always okay; kept in flops so the outputs come
  // straight from registers like every other output of the block.
  // no access is ever refused, so there is no error response path.
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= LPT_HRESP_OKAY;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= LPT_HRESP_OKAY;
    end
  end

endmodule // lpt_timer

// ---- dv/lpt_chk_properties.sv ----
`timescale 1ns/1ns
// pin-level checks of bus answers and interrupt gating
module lpt_chk
  import lpt_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  sys_rst_i,
  input wire lpt_pkg::lpt_ahb_req_t ahb_req_i,
  input wire logic [31:0]           hwdata_i,
  input wire logic [31:0]           hrdata_o,
  input wire logic                  hreadyout_o,
  input wire logic                  hresp_o,
  input wire logic                  expiry_irq_o
);
  logic       tk, rq, wph, en_q, msk_q;
  logic [4:0] wad;
  assign tk = ahb_req_i.hsel & ahb_req_i.hready & ahb_req_i.htrans[1];
  assign rq = tk & !ahb_req_i.hwrite;
  // shadow enable and mask, taken in the write data phase
  always_ff @(posedge mclk_i)
  begin
    wph <= tk & ahb_req_i.hwrite & !sys_rst_i;
    wad <= ahb_req_i.haddr[4:0];
    if (sys_rst_i)
      {en_q, msk_q} <= 2'h0;
    else if (wph && wad == 5'h08)
      en_q <= hwdata_i[0];
    else if (wph && wad == 5'h10)
      msk_q <= hwdata_i[0];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("ready low");
  a_resp_okay: assert property (hresp_o == LPT_HRESP_OKAY)
    else $error("resp not okay");
  a_irq_rst_low: assert property ($fell(sys_rst_i) |-> !expiry_irq_o)
    else $error("irq after reset");
  a_hole_zero: assert property (
    rq && ahb_req_i.haddr[4:0] == 5'h14 |=> hrdata_o == 32'h0)
    else $error("unmapped read");
  a_rdata_stands: assert property (!rq |=> $stable(hrdata_o))
    else $error("rdata moved");
  a_irq_masked: assert property (expiry_irq_o |-> $past(msk_q))
    else $error("masked irq");
  a_mask_drops: assert property (
    wph && wad == 5'h10 && !hwdata_i[0] |-> ##2 !expiry_irq_o)
    else $error("irq after mask");
  a_off_zero: assert property (
    rq && !en_q && (ahb_req_i.haddr[4:0] inside {5'h0, 5'h8})
    |=> hrdata_o == 32'h0)
    else $error("disabled not zero");
endmodule // lpt_chk
bind lpt_timer lpt_chk u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ahb_req_i(ahb_req_i),
  .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .expiry_irq_o(expiry_irq_o));

// ---- dv/lpt_tb.sv ----
`timescale 1ns/1ns
// bench: register model against the design, single ahb transfers
module tb;
  import lpt_pkg::*;
  logic         mclk_i, sys_rst_i, debug_halt_i, sel, wr;
  logic         hreadyout_o, hresp_o, expiry_irq_o;
  logic [1:0]   trn;
  logic [31:0]  adr, hwdata_i, hrdata_o, rd, nv;
  logic [31:0]  m [5];
  lpt_ahb_req_t req;
  int           err_total, comparisons, seed, n, cyc;
  assign req = '{sel, adr, trn, wr, 3'h2, hreadyout_o};
  lpt_timer uut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ahb_req_i(req),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .debug_halt_i(debug_halt_i),
    .expiry_irq_o(expiry_irq_o));
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a slave that never answers ends the run as a mismatch
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    n = 0;
    sel <= 1'b1;
    adr <= a;
    trn <= LPT_HTRANS_NONSEQ;
    wr  <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1 && ++n < 20);
    sel <= 1'b0;
    trn <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1 && ++n < 40);
    rd = hrdata_o;
    if (n >= 20)
    begin
      err_total++;
      final_report();
    end
  endtask
  // write and mirror the effect in the model
  task automatic wrr(input logic [31:0] a, d);
    bus(a, 1'b1, d);
    if (a == 32'h8)
    begin
      if (d[2] && !m[2][2] && m[1] != 0)
        m[0] = m[1];
      if (!d[2])
        m[0] = 0;
      m[2] = d & ((m[1] == 0) ? 32'h1b : 32'h1f);
      if (!d[0])
        foreach (m[i]) if (i < 3) m[i] = 0;
    end
    else if (a == 32'hc)
      m[3] = m[3] & ~d;
    else
      m[a >> 2] = (a == 32'h10) ? d & 32'h1 : d;
  endtask
  task automatic rdc(input logic [31:0] a);
    bus(a, 1'b0, 32'h0);
    chk(rd, (a < 32'h14) ? m[a >> 2] : 32'h0);
  endtask
  task automatic wirq(input int lim);
    for (cyc = 0; expiry_irq_o !== 1'b1 && cyc < lim; cyc++)
      @(posedge mclk_i);
    if (expiry_irq_o !== 1'b1)
    begin
      err_total++;
      final_report();
    end
  endtask
  initial
  begin
    {sel, wr, debug_halt_i, trn, adr, hwdata_i} = '0;
    {seed, err_total, comparisons} = {32'd75386, 64'd0};
    foreach (m[i]) m[i] = 32'h0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 24; i += 4) rdc(i);
    wrr(32'h8, 32'h1);
    wrr(32'h0, $random(seed));
    rdc(32'h0);
    wrr(32'h8, 32'h5);
    rdc(32'h8);
    $display("test reset and access done");
    nv = 4 + ($random(seed) & 7);
    wrr(32'h10, 32'h1);
    wrr(32'h4, nv);
    wrr(32'h8, 32'h15);
    rdc(32'h0);
    wrr(32'h4, nv + 3);
    rdc(32'h0);
    wrr(32'h8, 32'h5);
    wirq(nv + 6);
    chk(cyc >= nv && cyc <= nv + 3, 1);
    {m[0], m[2], m[3]} = {32'h0, 32'h1, 32'h1};
    rdc(32'h0);
    rdc(32'h8);
    wrr(32'hc, 32'h1);
    rdc(32'hc);
    $display("test one-shot done");
    wrr(32'h8, 32'h7);
    wirq(nv + 9);
    wrr(32'h8, 32'h17);
    rdc(32'h8);
    bus(32'h0, 1'b0, 32'h0);
    chk(rd <= nv + 3 && rd + 8 > nv + 3, 1);
    wrr(32'hc, 32'h1);
    wrr(32'h8, 32'h3);
    rdc(32'h0);
    rdc(32'hc);
    $display("test periodic done");
    debug_halt_i <= 1'b1;
    wrr(32'h4, nv);
    wrr(32'h8, 32'hd);
    repeat (6) @(posedge mclk_i);
    rdc(32'h0);
    wrr(32'h8, 32'h5);
    repeat (3) @(posedge mclk_i);
    bus(32'h0, 1'b0, 32'h0);
    chk(rd < nv, 1);
    debug_halt_i <= 1'b0;
    $display("test debug done");
    wrr(32'h10, 32'h0);
    wrr(32'h8, 32'h1);
    wrr(32'h8, 32'h5);
    repeat (20) @(posedge mclk_i);
    chk(expiry_irq_o, 0);
    m[3] = 1;
    rdc(32'hc);
    wrr(32'h8, 32'h0);
    for (int i = 0; i < 20; i += 4) rdc(i);
    $display("test mask and disable done");
    final_report();
  end
endmodule // tb
